//--- logic/serial_boot_loader.sv
// Serial boot loader: autobaud, handshake, blank check/erase, program load, hand-over.
// Assumes pins synchronous to clk_i; flash erase is an external engine with req/done.
`timescale 1ns/1ns
module serial_boot_loader #(
  parameter int DIV_W = 16,
  parameter int AW    = 10
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        flash_write_enable_pin_i,
  input  wire logic        mode_select_pin_a_i,
  input  wire logic        mode_select_pin_b_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe_o,
  output logic             flash_erase_req_o,
  input  wire logic        flash_erase_done_i,
  input  wire logic        flash_blank_i,
  input  wire logic        irq_i,
  output logic             irq_take_o,
  output logic             flash_read_en_o,
  output logic             boot_mode_o,
  output logic             user_prog_mode_o,
  output logic             jump_o,
  output logic [15:0]      jump_addr_o,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic [AW-1:0] ram_raddr_i,
  output logic [7:0]       ram_rdata_o
);
  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000, S_PREP  = 4'b0001, S_WAITL = 4'b0011, S_MEAS  = 4'b0010,
    S_SEND0 = 4'b0110, S_ACK   = 4'b0111, S_BLANK = 4'b0101, S_ERASE = 4'b0100,
    S_LOAD  = 4'b1100, S_JUMP  = 4'b1101, S_RUN   = 4'b1111, S_HALT  = 4'b1110
  } st_t;

  st_t             st_q, st_d;
  logic [1:0]      mode_q;
  logic            boot_q, user_q, fwe_q;
  logic [7:0]      prep_q;
  logic [DIV_W+3:0] low_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0]      ctrl_q, port4_q;
  logic            swe_q;
  logic [AW-1:0]   len_q, wptr_q;
  logic            rx_q;

  // Bit-time divisor from the low period of a zero byte (start + 8 data).
  function automatic logic [DIV_W-1:0] div_of(input logic [DIV_W+3:0] cnt);
    div_of = DIV_W'(cnt / (DIV_W+4)'(boot_loader_pkg::LOW_BITS));
  endfunction : div_of

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire is_boot = flash_write_enable_pin_i &&
                 {mode_select_pin_b_i, mode_select_pin_a_i} == boot_loader_pkg::MODE_BOOT;
  wire is_user = flash_write_enable_pin_i &&
                 {mode_select_pin_b_i, mode_select_pin_a_i} == boot_loader_pkg::MODE_USER_PROG;

  // Mode latched at reset release and again after each watchdog overflow; mode select pins are ignored afterwards, the FWE pin still gates swe_q.
  logic rel_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wdt_overflow_i) begin
      rel_q  <= 1'b0;
      boot_q <= 1'b0;
      user_q <= 1'b0;
      mode_q <= 2'b00;
    end else if (!rel_q) begin
      rel_q  <= 1'b1;
      boot_q <= is_boot;
      user_q <= is_user;
      mode_q <= {mode_select_pin_b_i, mode_select_pin_a_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fwe_q <= 1'b0;
      rx_q  <= 1'b1;
    end else begin
      fwe_q <= flash_write_enable_pin_i;
      rx_q  <= rxd_i;
    end
  end

  // ---------------------------------------------------------------
  // Serial engines
  // ---------------------------------------------------------------
  logic        rx_on, tx_on;
  logic        uart_rx_v, uart_tx_busy, tx_start;
  logic [7:0]  uart_rx_d;
  logic [DIV_W-1:0] rbit_q, tbit_q;
  logic [3:0]  rcnt_q, tcnt_q;
  logic [8:0]  rsh_q, tsh_q;
  logic        rbusy_q, rv_q, txd_q;

  assign rx_on = ctrl_q[boot_loader_pkg::CTRL_RX_ON];
  assign tx_on = ctrl_q[boot_loader_pkg::CTRL_TX_ON];
  assign uart_rx_v = rv_q;
  assign uart_rx_d = rsh_q[8:1];
  assign uart_tx_busy = tcnt_q != 4'd0;

  // Receiver: 8N1, samples mid-bit, drops frames with a bad stop bit.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rbusy_q <= 1'b0;
      rbit_q  <= '0;
      rcnt_q  <= 4'd0;
      rsh_q   <= '0;
      rv_q    <= 1'b0;
    end else begin
      rv_q <= 1'b0;
      if (!rbusy_q) begin
        if (rx_on && !rx_q) begin
          rbusy_q <= 1'b1;
          rbit_q  <= div_q >> 1;
          rcnt_q  <= 4'd0;
        end
      end else if (rbit_q != '0) begin
        rbit_q <= rbit_q - 1'b1;
      end else begin
        rbit_q <= div_q;
        rsh_q  <= {rx_q, rsh_q[8:1]};
        rcnt_q <= rcnt_q + 4'd1;
        if (rcnt_q == 4'(boot_loader_pkg::DATA_BITS + 1)) begin
          rbusy_q <= 1'b0;
          rv_q    <= rx_q;
          rsh_q   <= rsh_q;
        end
      end
    end
  end

  // Transmitter: start bit, 8 data bits, 1 stop bit, no parity.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tcnt_q <= 4'd0;
      tbit_q <= '0;
      tsh_q  <= '1;
      txd_q  <= 1'b1;
    end else if (tx_start && !uart_tx_busy) begin
      tsh_q  <= {1'b1, boot_loader_pkg::ADJUST_DONE_BYTE};
      txd_q  <= 1'b0;
      tbit_q <= div_q;
      tcnt_q <= 4'(boot_loader_pkg::DATA_BITS + 2);
    end else if (uart_tx_busy) begin
      if (tbit_q != '0) begin
        tbit_q <= tbit_q - 1'b1;
      end else begin
        tbit_q <= div_q;
        tcnt_q <= tcnt_q - 4'd1;
        txd_q  <= (tcnt_q == 4'd1) ? 1'b1 : tsh_q[0];
        tsh_q  <= {1'b1, tsh_q[8:1]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Boot sequence
  // ---------------------------------------------------------------
  wire prep_done = prep_q == 8'(boot_loader_pkg::PREP_STATES);
  wire load_last = wptr_q == len_q - 1'b1;
  wire prog_we   = st_q == S_LOAD && uart_rx_v;

  always_comb begin
    st_d     = st_q;
    tx_start = 1'b0;
    case (st_q)
      S_IDLE:  if (rel_q && boot_q) st_d = S_PREP;
      S_PREP:  if (prep_done) st_d = S_WAITL;
      S_WAITL: if (!rx_q) st_d = S_MEAS;
      S_MEAS:  if (rx_q) st_d = S_SEND0;
      S_SEND0: begin
        tx_start = 1'b1;
        st_d = S_ACK;
      end
      S_ACK:   if (uart_rx_v && uart_rx_d == boot_loader_pkg::HOST_ACK_BYTE) st_d = S_BLANK;
      S_BLANK: st_d = flash_blank_i ? S_LOAD : S_ERASE;
      S_ERASE: if (flash_erase_done_i) st_d = S_LOAD;
      S_LOAD:  if (prog_we && load_last) st_d = S_JUMP;
      S_JUMP:  if (!uart_tx_busy) st_d = S_RUN;
      S_RUN:   st_d = S_RUN;
      S_HALT:  st_d = S_HALT;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wdt_overflow_i) begin
      st_q   <= S_IDLE;
      prep_q <= 8'd0;
      low_q  <= '0;
      div_q  <= '1;
      wptr_q <= '0;
      flash_erase_req_o <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == S_PREP) prep_q <= prep_q + 8'd1;
      if (st_q == S_MEAS) low_q <= low_q + 1'b1;
      if (st_q == S_MEAS && rx_q) div_q <= div_of(low_q);
      flash_erase_req_o <= st_d == S_ERASE;
      if (prog_we) wptr_q <= wptr_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  wire erasing = st_q == S_ERASE || swe_q;
  wire [7:0] status_w = {4'd0, st_q};
  wire [7:0] flash_w  = {6'd0, erasing, swe_q};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= boot_loader_pkg::CTRL_RESET;
      port4_q <= 8'h00;
      swe_q   <= 1'b0;
      len_q   <= '1;
      reg_rdata_o <= 8'h00;
    end else begin
      if (st_q == S_MEAS && st_d == S_SEND0) begin
        ctrl_q <= 8'h03;
      end else if (st_q == S_JUMP && st_d == S_RUN) begin
        ctrl_q  <= 8'h00;
        port4_q <= 8'h03;
      end else if (reg_we_i) begin
        case (reg_addr_i)
          boot_loader_pkg::REG_CTRL:   ctrl_q  <= reg_wdata_i;
          boot_loader_pkg::REG_LEN_LO: len_q   <= AW'({len_q[AW-1:8], reg_wdata_i});
          boot_loader_pkg::REG_LEN_HI: len_q   <= AW'({reg_wdata_i, len_q[7:0]});
          boot_loader_pkg::REG_FLASH:  swe_q   <= reg_wdata_i[boot_loader_pkg::FLASH_SW_WE] && fwe_q;
          boot_loader_pkg::REG_PORT4:  port4_q <= reg_wdata_i;
          default: ;
        endcase
      end
      if (!fwe_q) swe_q <= 1'b0;
      reg_rdata_o <= 8'h00;
      if (reg_re_i) begin
        case (reg_addr_i)
          boot_loader_pkg::REG_CTRL:   reg_rdata_o <= ctrl_q;
          boot_loader_pkg::REG_STATUS: reg_rdata_o <= status_w;
          boot_loader_pkg::REG_DIV_LO: reg_rdata_o <= div_q[7:0];
          boot_loader_pkg::REG_DIV_HI: reg_rdata_o <= 8'(div_q >> 8);
          boot_loader_pkg::REG_LEN_LO: reg_rdata_o <= 8'(len_q);
          boot_loader_pkg::REG_LEN_HI: reg_rdata_o <= 8'(len_q >> 8);
          boot_loader_pkg::REG_FLASH:  reg_rdata_o <= flash_w;
          boot_loader_pkg::REG_PORT4:  reg_rdata_o <= port4_q;
          default:                     reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Program RAM and outputs
  // ---------------------------------------------------------------
  prog_ram #(.AW(AW)) u_ram (
    .clk_i   (clk_i),
    .we_i    (prog_we),
    .waddr_i (wptr_q),
    .wdata_i (uart_rx_d),
    .raddr_i (ram_raddr_i),
    .rdata_o (ram_rdata_o)
  );

  assign txd_o            = (st_q == S_RUN) ? port4_q[1] : (tx_on ? txd_q : 1'b1);
  assign txd_oe_o         = (st_q == S_RUN) ? port4_q[0] : tx_on;
  assign irq_take_o       = irq_i && !erasing;
  assign flash_read_en_o  = !swe_q;
  assign boot_mode_o      = boot_q;
  assign user_prog_mode_o = user_q;
  assign jump_o           = st_q == S_RUN;
  assign jump_addr_o      = (st_q == S_RUN) ? boot_loader_pkg::ENTRY_ADDR : boot_loader_pkg::BOOT_AREA_LO;
endmodule : serial_boot_loader

//--- logic/boot_loader_pkg.sv
// Constants used by the serial boot loader; its program memory uses none of them.
// Assumes a 125 MHz system clock and a synchronous active-low reset.
package boot_loader_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned PREP_STATES      = 100;
  localparam int unsigned MODE_SETUP_STATES = 4;
  localparam int unsigned EXIT_RESET_CYC   = 10;
  localparam logic [15:0] BOOT_AREA_LO     = 16'hf780;
  localparam logic [15:0] BOOT_AREA_HI     = 16'hfb7f;
  localparam logic [15:0] PROG_AREA_LO     = 16'hfb80;
  localparam logic [15:0] PROG_AREA_HI     = 16'hff7f;
  localparam logic [15:0] ENTRY_ADDR       = 16'hfb80;
  localparam logic [7:0]  ADJUST_DONE_BYTE = 8'h00;
  localparam logic [7:0]  HOST_ACK_BYTE    = 8'h55;
  localparam logic [7:0]  BLANK_BYTE       = 8'hff;
  localparam int unsigned DATA_BITS        = 8;
  localparam int unsigned LOW_BITS         = 9;
  localparam logic [1:0]  MODE_BOOT        = 2'b00;
  localparam logic [1:0]  MODE_USER_PROG   = 2'b10;
  localparam logic [4:0]  REG_CTRL         = 5'h00;
  localparam logic [4:0]  REG_STATUS       = 5'h01;
  localparam logic [4:0]  REG_DIV_LO       = 5'h02;
  localparam logic [4:0]  REG_DIV_HI       = 5'h03;
  localparam logic [4:0]  REG_LEN_LO       = 5'h04;
  localparam logic [4:0]  REG_LEN_HI       = 5'h05;
  localparam logic [4:0]  REG_FLASH        = 5'h06;
  localparam logic [4:0]  REG_PORT4        = 5'h07;
  localparam int unsigned CTRL_RX_ON       = 0;
  localparam int unsigned CTRL_TX_ON       = 1;
  localparam int unsigned FLASH_SW_WE      = 0;
  localparam int unsigned FLASH_BUSY       = 1;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
endpackage : boot_loader_pkg

//--- logic/prog_ram.sv
// Byte-wide program RAM with registered read data.
// Assumes one clock; write and read addresses are word indices.
`timescale 1ns/1ns
module prog_ram #(
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : prog_ram

//--- tb/boot_loader_checker.sv
// Port checker for the serial boot loader.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module boot_loader_checker (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        txd_o,
  input  wire logic        txd_oe_o,
  input  wire logic        flash_erase_req_o,
  input  wire logic        irq_take_o,
  input  wire logic        boot_mode_o,
  input  wire logic        user_prog_mode_o,
  input  wire logic        jump_o,
  input  wire logic [15:0] jump_addr_o,
  input  wire logic        reg_re_i,
  input  wire logic [7:0]  reg_rdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [6:0] prep_q;
  logic [6:0] prep_d;
  assign prep_d = (prep_q == 7'h7f) ? prep_q : prep_q + 7'h01;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) prep_q <= 7'h00;
    else prep_q <= prep_d;
  end
  property p_prep; prep_q < 7'h64 |-> txd_o; endproperty
  a_prep: assert property (p_prep) else $error("Transmit before preparation ended.");
  property p_erase_irq; flash_erase_req_o |-> !irq_take_o; endproperty
  a_erase_irq: assert property (p_erase_irq) else $error("Interrupt taken during erase.");
  property p_erase_mode; flash_erase_req_o |-> boot_mode_o; endproperty
  a_erase_mode: assert property (p_erase_mode) else $error("Erase outside boot mode.");
  property p_jump_addr; jump_o |-> jump_addr_o == 16'hfb80; endproperty
  a_jump_addr: assert property (p_jump_addr) else $error("Wrong entry address.");
  property p_jump_hold; jump_o && !wdt_overflow_i |=> jump_o; endproperty
  a_jump_hold: assert property (p_jump_hold) else $error("Hand-over dropped.");
  property p_jump_tx; jump_o |-> txd_oe_o && txd_o && !flash_erase_req_o; endproperty
  a_jump_tx: assert property (p_jump_tx) else $error("Transmit pin not high output.");
  property p_modes; !(boot_mode_o && user_prog_mode_o); endproperty
  a_modes: assert property (p_modes) else $error("Two modes at once.");
  property p_rdata; !$past(reg_re_i) |-> reg_rdata_o == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("Read data outside read cycle.");
endmodule : boot_loader_checker
bind serial_boot_loader boot_loader_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .wdt_overflow_i(wdt_overflow_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .flash_erase_req_o(flash_erase_req_o),
  .irq_take_o(irq_take_o), .boot_mode_o(boot_mode_o), .user_prog_mode_o(user_prog_mode_o),
  .jump_o(jump_o), .jump_addr_o(jump_addr_o), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

//--- tb/host_model.sv
// Host side of the boot serial link.
// Assumes the transmit line is pulled up when the loader does not drive it.
`timescale 1ns/1ns
module host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_i,
  output logic      rxd_o,
  input  wire logic txd_i
);
  initial rxd_o = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= fr[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hff;
    while (txd_i !== 1'b0 && n < 40 * BIT_CYC) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      b[i] = txd_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
  endtask : recv_byte
endmodule : host_model

//--- tb/serial_boot_loader_tb_top.sv
// Testbench for the serial boot loader: boot load, hand-over, user program mode.
// Assumes a pulled-up transmit line and an erase engine modelled here.
`timescale 1ns/1ns
module serial_boot_loader_tb_top;
  localparam int BIT = 16;
  logic clk_i = 1'b0, rst_n_i = 1'b0, flash_write_enable_pin = 1'b1, mode_a = 1'b0, mode_b = 1'b0;
  logic erase_done = 1'b0, blank = 1'b0, irq = 1'b1, we = 1'b0, re = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00, rd;
  logic [9:0] raddr = 10'h000;
  logic [7:0] ecnt = 8'h00;
  wire logic txd, txd_oe, erase_req, irq_take, rd_en, boot, user, jump, rxd;
  wire logic [15:0] jaddr;
  wire logic [7:0] rdata, ram_rdata;
  wire logic line = txd_oe ? txd : 1'b1;
  int mismatches = 0, compares = 0, cyc = 0, n;
  serial_boot_loader u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wdt_overflow_i(1'b0),
    .flash_write_enable_pin_i(flash_write_enable_pin), .mode_select_pin_a_i(mode_a), .mode_select_pin_b_i(mode_b),
    .rxd_i(rxd), .txd_o(txd), .txd_oe_o(txd_oe), .flash_erase_req_o(erase_req),
    .flash_erase_done_i(erase_done), .flash_blank_i(blank), .irq_i(irq), .irq_take_o(irq_take),
    .flash_read_en_o(rd_en), .boot_mode_o(boot), .user_prog_mode_o(user), .jump_o(jump),
    .jump_addr_o(jaddr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .ram_raddr_i(raddr), .ram_rdata_o(ram_rdata));
  host_model #(.BIT_CYC(BIT)) u_host (.clk_i(clk_i), .rxd_o(rxd), .txd_i(line));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Erase engine and run limit.
  // ----------------------------------------
  always @(posedge clk_i) begin
    ecnt <= erase_req ? ecnt + 8'h01 : 8'h00;
    erase_done <= (ecnt == 8'd20);
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic reg_acc(input logic w, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= wd;
    we <= w;
    re <= !w;
    @(posedge clk_i);
    we <= 1'b0;
    re <= 1'b0;
    #1 d = rdata;
  endtask : reg_acc
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Test sequence.
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check(boot, 1'b1);
    reg_acc(1'b1, 5'h04, 8'h04, rd);
    reg_acc(1'b1, 5'h05, 8'h00, rd);
    repeat (120) @(posedge clk_i);
    fork
      u_host.send_byte(8'h00);
      u_host.recv_byte(rd);
    join
    check(rd, 8'h00);
    u_host.send_byte(8'h55);
    for (n = 0; n < 3000 && !erase_req; n++) @(posedge clk_i);
    #1 check(erase_req, 1'b1);
    check(irq_take, 1'b0);
    for (n = 0; n < 3000 && erase_req; n++) @(posedge clk_i);
    for (int i = 0; i < 4; i++) u_host.send_byte(8'ha0 + i[7:0]);
    for (n = 0; n < 3000 && !jump; n++) @(posedge clk_i);
    #1 check(jaddr, 16'hfb80);
    check({txd_oe, txd}, 2'b11);
    reg_acc(1'b0, 5'h00, 8'h00, rd);
    check(rd, 8'h00);
    reg_acc(1'b0, 5'h02, 8'h00, rd);
    check(rd, 8'(BIT - 1));
    reg_acc(1'b0, 5'h07, 8'h00, rd);
    check(rd, 8'h03);
    reg_acc(1'b0, 5'h1f, 8'h00, rd);
    check(rd, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      raddr <= i[9:0];
      @(posedge clk_i);
      #1 check(ram_rdata, 8'ha0 + i[7:0]);
    end
    $display("test boot load done");
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    mode_b <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check({user, boot, irq_take}, 3'b101);
    reg_acc(1'b1, 5'h06, 8'h01, rd);
    #1 check(rd_en, 1'b0);
    check(irq_take, 1'b0);
    reg_acc(1'b1, 5'h06, 8'h00, rd);
    #1 check(rd_en, 1'b1);
    $display("test user program mode done");
    give_verdict();
  end
endmodule : serial_boot_loader_tb_top
